// [include/ufmtx_pkg.sv]
`default_nettype none
package ufmtx_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned SYS_CLK_HZ  = 10_000_000;
    localparam int unsigned RATE_MIN_HZ = 50_000;
    localparam int unsigned RATE_MAX_HZ = 5_000_000;
    // half bit period in system cycles; fastest rounds down, slowest rounds down
    localparam logic [7:0]  HALF_DIV_MIN = 8'(SYS_CLK_HZ / (2 * RATE_MAX_HZ));
    localparam logic [7:0]  HALF_DIV_MAX = 8'(SYS_CLK_HZ / (2 * RATE_MIN_HZ));

    // ----------------------------------------
    // framing
    // ----------------------------------------
    localparam logic [3:0]  SLOTS_PER_BYTE = 4'h9;  // eight data bits plus dummy
    localparam logic        CMD_WRITE      = 1'b0;
    localparam logic        DUMMY_LEVEL    = 1'b1;
    localparam int unsigned FIFO_DEPTH     = 4;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] data;
    } ufmtx_byte_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_SHIFT  = 3'b010,
        ST_LOAD   = 3'b011,
        ST_STOP_L = 3'b100,
        ST_STOP_H = 3'b101
    } ufmtx_state_t;

endpackage
`default_nettype wire

// [design/ufmtx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module ufmtx_fifo
#(
    parameter int unsigned W = 8,
    parameter int unsigned D = 4
)
(
    input  wire logic         clk_sys_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);

    localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wr;
        logic [AW-1:0]       rd;
        logic [AW:0]         cnt;
    } ufmtx_fifo_state_t;

    ufmtx_fifo_state_t st;
    ufmtx_fifo_state_t next_st;
    logic              push;
    logic              pop;

    // ----------------------------------------
    // flags and handshakes
    // ----------------------------------------
    assign in_ready_o  = (st.cnt != (AW+1)'(D));  // honest full stalls the source
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = st.mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer wrap written out so depths that are not powers of two work
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr = (st.wr == AW'(D-1)) ? '0 : st.wr + AW'(1);
        end
        if (pop)
        begin
            next_st.rd = (st.rd == AW'(D-1)) ? '0 : st.rd + AW'(1);
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

endmodule
`default_nettype wire

// [design/ufmtx_core.sv]
`timescale 1ns/1ps
`default_nettype none
module ufmtx_core
#(
    parameter int unsigned DEPTH = ufmtx_pkg::FIFO_DEPTH
)
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   arst_n_i,
    input  wire logic [7:0]             half_div_i,
    input  wire logic                   start_i,
    input  wire logic [6:0]             slave_addr_i,
    input  wire logic                   stop_request_bit_i,
    input  wire ufmtx_pkg::ufmtx_byte_t tx_byte_i,
    input  wire logic                   tx_valid_i,
    output logic                        tx_ready_o,
    output logic                        ufm_clock_out_o,
    output logic                        ufm_data_out_o,
    output logic                        busy_o,
    output logic                        done_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        ufmtx_pkg::ufmtx_state_t fsm;
        logic                    high_half;
        logic [7:0]              cnt;
        logic [7:0]              div;
        logic [3:0]              slot;
        logic [8:0]              sh;
        logic                    scl;
        logic                    sda;
        logic                    stop_pend;
        logic                    busy;
        logic                    done;
        logic                    rdy;
    } ufmtx_core_state_t;

    ufmtx_core_state_t      st;
    ufmtx_core_state_t      next_st;
    ufmtx_pkg::ufmtx_byte_t fifo_data;
    logic                   fifo_valid;
    logic                   fifo_pop;
    logic                   tick;
    logic                   in_ready;
    logic [7:0]             div_clamped;

    // ----------------------------------------
    // data buffer
    // ----------------------------------------
    ufmtx_fifo
    #(
        .W ($bits(ufmtx_pkg::ufmtx_byte_t)),
        .D (DEPTH)
    )
    u_fifo
    (
        .clk_sys_i   (clk_sys_i),
        .arst_n_i    (arst_n_i),
        .in_data_i   (tx_byte_i),
        .in_valid_i  (tx_valid_i && st.rdy),
        .in_ready_o  (in_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // clamp the divider so an out-of-range setting still lands in band
    always_comb
    begin
        if (half_div_i < ufmtx_pkg::HALF_DIV_MIN)
            div_clamped = ufmtx_pkg::HALF_DIV_MIN;
        else if (half_div_i > ufmtx_pkg::HALF_DIV_MAX)
            div_clamped = ufmtx_pkg::HALF_DIV_MAX;
        else
            div_clamped = half_div_i;
    end

    // half-bit enable pulse from the divider
    assign tick     = (st.fsm != ufmtx_pkg::ST_IDLE) && (st.cnt == st.div - 8'h01);
    assign fifo_pop = tick && (st.fsm == ufmtx_pkg::ST_LOAD) && !st.stop_pend && fifo_valid;

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    // the divider is latched per frame so the rate cannot jump mid-bit
    always_comb
    begin
        next_st      = st;
        next_st.done = 1'b0;
        next_st.rdy  = in_ready && !(tx_valid_i && st.rdy);  // registered, may trail the fifo a cycle
        next_st.cnt  = tick ? 8'h00 : st.cnt + 8'h01;
        if (st.fsm != ufmtx_pkg::ST_IDLE && stop_request_bit_i)
            next_st.stop_pend = 1'b1;
        unique case (st.fsm)
            ufmtx_pkg::ST_IDLE:
            begin
                next_st.scl       = 1'b1;
                next_st.sda       = 1'b1;
                next_st.cnt       = 8'h00;
                next_st.stop_pend = 1'b0;
                next_st.busy      = 1'b0;
                if (start_i)
                begin
                    next_st.fsm  = ufmtx_pkg::ST_START;
                    next_st.div  = div_clamped;
                    next_st.sh   = {slave_addr_i, ufmtx_pkg::CMD_WRITE, ufmtx_pkg::DUMMY_LEVEL};
                    next_st.busy = 1'b1;
                end
            end
            ufmtx_pkg::ST_START:
            begin
                if (tick)
                begin
                    next_st.sda       = 1'b0;
                    next_st.fsm       = ufmtx_pkg::ST_SHIFT;
                    next_st.high_half = 1'b1;
                    next_st.slot      = 4'h0;
                end
            end
            ufmtx_pkg::ST_SHIFT:
            begin
                if (tick)
                begin
                    if (!st.high_half)
                    begin
                        next_st.scl       = 1'b1;
                        next_st.high_half = 1'b1;
                    end
                    else if (st.slot == ufmtx_pkg::SLOTS_PER_BYTE)
                    begin
                        next_st.scl = 1'b0;
                        next_st.fsm = ufmtx_pkg::ST_LOAD;
                    end
                    else
                    begin
                        // falling edge and next bit leave on the same edge, both push-pull
                        next_st.scl       = 1'b0;
                        next_st.sda       = st.sh[8];
                        next_st.sh        = {st.sh[7:0], 1'b0};
                        next_st.slot      = st.slot + 4'h1;
                        next_st.high_half = 1'b0;
                    end
                end
            end
            ufmtx_pkg::ST_LOAD:
            begin
                // clock parks low while the buffer runs dry; no ack is ever read
                if (tick)
                begin
                    if (st.stop_pend)
                    begin
                        next_st.sda = 1'b0;
                        next_st.fsm = ufmtx_pkg::ST_STOP_L;
                    end
                    else if (fifo_valid)
                    begin
                        next_st.sda       = fifo_data.data[7];
                        next_st.slot      = 4'h1;
                        next_st.high_half = 1'b0;
                        next_st.fsm       = ufmtx_pkg::ST_SHIFT;
                        next_st.sh        = {fifo_data.data[6:0], ufmtx_pkg::DUMMY_LEVEL, 1'b0};
                    end
                end
            end
            ufmtx_pkg::ST_STOP_L:
            begin
                if (tick)
                begin
                    next_st.scl = 1'b1;
                    next_st.fsm = ufmtx_pkg::ST_STOP_H;
                end
            end
            ufmtx_pkg::ST_STOP_H:
            begin
                if (tick)
                begin
                    next_st.sda  = 1'b1;
                    next_st.fsm  = ufmtx_pkg::ST_IDLE;
                    next_st.done = 1'b1;
                end
            end
            default:
            begin
                next_st.fsm = ufmtx_pkg::ST_IDLE;
            end
        endcase
    end

    // reset leaves the bus idle high
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st     <= '0;
            st.scl <= 1'b1;
            st.sda <= 1'b1;
            st.div <= ufmtx_pkg::HALF_DIV_MIN;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs, straight from flops
    // ----------------------------------------
    assign ufm_clock_out_o = st.scl;
    assign ufm_data_out_o  = st.sda;
    assign busy_o          = st.busy;
    assign done_o          = st.done;
    assign tx_ready_o      = st.rdy;

endmodule
`default_nettype wire

// [verification/ufmtx_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// serial line checker
// ----
module ufmtx_monitor
(
    input wire logic       clk_sys_i,
    input wire logic       arst_n_i,
    input wire logic [7:0] half_div_i,
    input wire logic       start_i,
    input wire logic [6:0] slave_addr_i,
    input wire logic       busy_o,
    input wire logic       done_o,
    input wire logic       ufm_clock_out_o,
    input wire logic       ufm_data_out_o
);
    logic       framed;
    logic       addr_ph;
    logic [3:0] nbit;
    logic [7:0] hcnt;
    logic [7:0] hd;
    logic [6:0] addr;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // bit position within the byte, counted on rising serial clock; framed once the clock first falls
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            framed  <= 1'b0;
            addr_ph <= 1'b1;
            nbit    <= 4'h0;
            hcnt    <= 8'h00;
            hd      <= 8'h00;
            addr    <= 7'h00;
        end
        else
        begin
            framed  <= busy_o && (framed || !ufm_clock_out_o);
            addr_ph <= !busy_o || (addr_ph && !(nbit == 4'h8 && $rose(ufm_clock_out_o)));
            hcnt    <= $changed(ufm_clock_out_o) ? 8'h01 : hcnt + 8'h01;
            if (!busy_o)
                nbit <= 4'h0;
            else if ($rose(ufm_clock_out_o))
                nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
            // latched only when the request is taken, a start while busy is ignored; clamped into band
            if (start_i && !busy_o)
            begin
                if (half_div_i < ufmtx_pkg::HALF_DIV_MIN)
                    hd <= ufmtx_pkg::HALF_DIV_MIN;
                else if (half_div_i > ufmtx_pkg::HALF_DIV_MAX)
                    hd <= ufmtx_pkg::HALF_DIV_MAX;
                else
                    hd <= half_div_i;
                addr <= slave_addr_i;
            end
        end
    end
    a_idle_high: assert property (!busy_o |-> ufm_clock_out_o && ufm_data_out_o)
        else $error("bus not high while idle");
    a_start_edge: assert property ($rose(busy_o) |-> ##[1:101] ($fell(ufm_data_out_o) && ufm_clock_out_o))
        else $error("no start edge after take");
    a_stop_edge: assert property (done_o |-> ufm_clock_out_o && $rose(ufm_data_out_o) && $past(ufm_clock_out_o))
        else $error("stop edge missing at done");
    a_data_steady: assert property ($changed(ufm_data_out_o) && ufm_clock_out_o && $past(ufm_clock_out_o)
        |-> !framed || done_o)
        else $error("data moved while clock high");
    a_ninth_high: assert property ($rose(ufm_clock_out_o) && busy_o && nbit == 4'h8 |-> ufm_data_out_o)
        else $error("ninth bit not high");
    a_addr_bits: assert property ($rose(ufm_clock_out_o) && busy_o && addr_ph && nbit < 4'h7
        |-> ufm_data_out_o == addr[3'h6 - nbit[2:0]])
        else $error("address bit wrong");
    a_write_bit: assert property ($rose(ufm_clock_out_o) && busy_o && addr_ph && nbit == 4'h7 |-> !ufm_data_out_o)
        else $error("command bit not write");
    a_stop_place: assert property (done_o |-> nbit == 4'h1 && !addr_ph)
        else $error("stop not after a ninth clock");
    a_half_high: assert property ($fell(ufm_clock_out_o) && framed |-> hcnt == hd)
        else $error("clock high time wrong");
endmodule
bind ufmtx_core ufmtx_monitor u_mon
(
    .clk_sys_i       (clk_sys_i),
    .arst_n_i        (arst_n_i),
    .half_div_i      (half_div_i),
    .start_i         (start_i),
    .slave_addr_i    (slave_addr_i),
    .busy_o          (busy_o),
    .done_o          (done_o),
    .ufm_clock_out_o (ufm_clock_out_o),
    .ufm_data_out_o  (ufm_data_out_o)
);
`default_nettype wire

// [verification/ufmtx_slave.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// write-only receiver on the serial bus
// ----
// only inputs on the line side, so it never drives clock or data
module ufmtx_slave
(
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic      [9:0] word_o,
    output logic            word_stb_o
);
    logic [8:0] sh;
    int         n;
    logic       inf;
    initial
    begin
        word_stb_o = 1'b0;
        word_o     = 10'h000;
        inf        = 1'b0;
    end
    // falling data under high clock opens a frame; judged a moment later because
    // clock and data leave the same system edge and their update order is arbitrary
    always @(negedge sda_i)
    begin
        #1;
        if (scl_i === 1'b1 && sda_i === 1'b0)
        begin
            n   = 0;
            inf = 1'b1;
        end
    end
    // rising data under high clock closes it; reports stop-clock bits since the last ninth
    always @(posedge sda_i)
    begin
        #1;
        if (scl_i === 1'b1 && sda_i === 1'b1 && inf)
        begin
            inf        = 1'b0;
            word_o     = {1'b1, 9'(n)};
            word_stb_o = ~word_stb_o;
        end
    end
    // one bit per rising clock, nine bits make a word with its dummy bit last
    always @(posedge scl_i)
        if (inf)
        begin
            sh = {sh[7:0], sda_i};
            n++;
            if (n == 9)
            begin
                n          = 0;
                word_o     = {1'b0, sh};
                word_stb_o = ~word_stb_o;
            end
        end
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// frame-level bench
// ----
module tb;
    logic                   clk_sys_i;
    logic                   arst_n_i;
    logic [7:0]             half_div;
    logic                   start;
    logic [6:0]             addr;
    logic                   stop_req;
    ufmtx_pkg::ufmtx_byte_t tx_byte;
    logic                   tx_valid;
    logic                   tx_ready;
    logic                   scl;
    logic                   sda;
    logic                   busy;
    logic                   done;
    logic [9:0]             word;
    logic                   stb;
    logic [9:0]             exp_q[$];
    logic [31:0]            seed = 32'h5ad1_b3de;
    int                     err_total;
    int                     n_checks;
    int                     n_got;
    ufmtx_core uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .half_div_i(half_div), .start_i(start),
        .slave_addr_i(addr), .stop_request_bit_i(stop_req), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .ufm_clock_out_o(scl), .ufm_data_out_o(sda), .busy_o(busy), .done_o(done));
    ufmtx_slave u_slave (.scl_i(scl), .sda_i(sda), .word_o(word), .word_stb_o(stb));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        n_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // valid stays up between pushes so it is never lowered and raised in one step
    task automatic push(input logic [7:0] b);
        @(negedge clk_sys_i);
        tx_valid     = 1'b1;
        tx_byte.data = b;
        do @(posedge clk_sys_i); while (tx_ready !== 1'b1);
    endtask
    task automatic pulse_stop();
        @(negedge clk_sys_i);
        stop_req = 1'b1;
        @(negedge clk_sys_i);
        stop_req = 1'b0;
    endtask
    // one frame; a second start with another address is held while busy and must be ignored
    task automatic frame(input logic [7:0] hd, input int nb);
        logic [6:0] a;
        logic [7:0] b;
        int         base;
        a    = 7'(rnd());
        base = n_got;
        exp_q.push_back({1'b0, a, 1'b0, 1'b1});
        @(negedge clk_sys_i);
        half_div = hd;
        addr     = a;
        start    = 1'b1;
        @(negedge clk_sys_i);
        addr = ~a;
        @(negedge clk_sys_i);
        start = 1'b0;
        if (nb == 0)
        begin
            exp_q.push_back(10'h201);
            pulse_stop();
        end
        for (int i = 0; i < nb; i++)
        begin
            b = 8'(rnd());
            exp_q.push_back({1'b0, b, 1'b1});
            push(b);
        end
        if (nb > 0)
        begin
            @(negedge clk_sys_i);
            tx_valid = 1'b0;
            wait (n_got >= base + nb);
            repeat (3 * hd) @(negedge clk_sys_i);
            exp_q.push_back(10'h201);
            pulse_stop();
        end
        for (int k = 0; k < 40000 && done !== 1'b1; k++) @(negedge clk_sys_i);
        if (done !== 1'b1)
        begin
            err_total++;
            complete_run();
        end
        @(negedge clk_sys_i);
        check({8'h00, done, busy}, 10'h000);
    endtask
    // every word the receiver reports is matched against the oldest note
    always @(stb)
        if ($time > 0)
        begin
            n_got++;
            if (exp_q.size() == 0)
                check(word, ~word);
            else
                check(word, exp_q.pop_front());
        end
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #6_000_000;
        err_total++;
        complete_run();
    end
    // fastest and slowest rates, stop during address, long frames filling the buffer
    initial
    begin
        arst_n_i = 1'b0;
        {start, stop_req, tx_valid} = 3'b000;
        tx_byte  = '0;
        half_div = 8'h01;
        addr     = 7'h00;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check({5'h00, tx_ready, busy, done, scl, sda}, 10'h003);
        arst_n_i = 1'b1;
        frame(8'h00, 0);
        frame(8'h01, 6);
        frame(8'h64, 2);
        frame(8'(rnd() % 100) + 8'h01, 9);
        complete_run();
    end
endmodule
`default_nettype wire
